// File: core/tmc_pkg.sv
// Types shared by the timer/counter design
package tmc_pkg;

    typedef enum logic [1:0]
    {
        TMC_MODE_TIMER = 2'b00,
        TMC_MODE_SYNC = 2'b01,
        TMC_MODE_ASYNC = 2'b10
    } tmc_mode_t;

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] first_ctrl;
        logic [15:0] count;
        logic [7:0] hbuf;
        logic [2:0] ps_cnt;
        logic [1:0] phase;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic ext_s4;
        logic armed;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] prio;
        logic [7:0] rdata;
        logic irq;
        logic irq_high;
        logic unit1_this;
        logic unit2_this;
        logic [1:0] port_read;
        logic [1:0] port_dir;
        tmc_mode_t mode;
    } tmc_state_t;

endpackage

// File: core/tmc_regs.svh
// Register offsets, bit positions, reset values and counts of the timer/counter
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ==========================================
// Register offsets
`define TMC_OFF_CTRL 8'h00
`define TMC_OFF_COUNT_LO 8'h01
`define TMC_OFF_COUNT_HI 8'h02
`define TMC_OFF_FLAGS 8'h03
`define TMC_OFF_ENABLES 8'h04
`define TMC_OFF_PRIO 8'h05
`define TMC_OFF_FIRST_CTRL 8'h06

// ==========================================
// Control register and overflow bit positions
`define TMC_BIT_WIDE 7
`define TMC_BIT_SEL_HI 6
`define TMC_BIT_PS_HI 5
`define TMC_BIT_PS_LO 4
`define TMC_BIT_SEL_LO 3
`define TMC_BIT_UNSYNC 2
`define TMC_BIT_CS 1
`define TMC_BIT_RUN 0
`define TMC_BIT_OSC_EN 3
`define TMC_BIT_OVF 1

// ==========================================
// Reset values and implemented-bit masks
`define TMC_RST_CTRL 8'h00
`define TMC_RST_FLAGS 8'h00
`define TMC_RST_ENABLES 8'h00
`define TMC_RST_PRIO 8'h1f
`define TMC_RST_FIRST_CTRL 8'h00
`define TMC_MASK_PRIO 8'h1f
`define TMC_MASK_OVF 8'h02

// ==========================================
// Compare trigger mode and instruction-cycle division
`define TMC_TRIG_MODE 4'hb
`define TMC_INSTR_LAST 2'h3
`define TMC_COUNT_MAX 16'hffff

`endif

// File: core/tmc_timer.sv
// Sixteen-bit timer/counter with prescaler, wide access, trigger reset and interrupt
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`include "tmc_regs.svh"

// Functional notes
// - Sixteen-bit count wraps from all ones to zero
// - Wrap latches overflow flag; interrupt needs enable
// - Wide bit selects one 16-bit or byte access
// - Wide mode buffers high byte through low access
// - High buffer write leaves prescaler alone
// - Select bits assign timer to compare units
// - Prescale field divides by 1, 2, 4, 8
// - Unsync bit chooses external synchronisation
// - External count starts at rise after fall
// - Internal source counts once per instruction cycle
// - Mode follows source and sync selection
// - Run bit starts and stops counting
// - Shared oscillator enable makes oscillator the external source
// - Enabled oscillator forces pins input, reads zero
// - Compare trigger in mode 1011 clears count
// - Trigger clear never sets overflow flag
// - Software write beats simultaneous trigger clear
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ext_clock_pin_i,
    input wire logic osc_clock_i,
    input wire logic trigger_i,
    input wire logic [3:0] compare_unit_mode_i,
    input wire logic [1:0] port_direction_i,
    input wire logic [1:0] port_pin_i,
    output logic [1:0] port_direction_o,
    output logic [1:0] port_read_o,
    output logic [15:0] count_o,
    output logic unit1_this_o,
    output logic unit2_this_o,
    output logic irq_o,
    output logic irq_high_prio_o,
    output logic [1:0] mode_o
);

    tmc_state_t st_r;
    tmc_state_t st_nxt;

    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_flags;
    logic trig;
    logic ext_rise;
    logic src_edge;
    logic ps_done;
    logic tick;
    logic [2:0] ps_limit;

    // ==========================================
    // Bus decode
    always_comb
    begin
        wr_ctrl = wr_i && (addr_i == `TMC_OFF_CTRL);
        wr_lo = wr_i && (addr_i == `TMC_OFF_COUNT_LO);
        wr_hi = wr_i && (addr_i == `TMC_OFF_COUNT_HI);
        rd_lo = rd_i && (addr_i == `TMC_OFF_COUNT_LO);
        rd_flags = rd_i && (addr_i == `TMC_OFF_FLAGS);
        trig = trigger_i && (compare_unit_mode_i == `TMC_TRIG_MODE);
    end

    // ==========================================
    // Count source and prescaler
    always_comb
    begin
        // Sync mode costs one more stage so edges align like the internal path
        if (st_r.ctrl[`TMC_BIT_UNSYNC])
        begin
            ext_rise = st_r.ext_s2 && !st_r.ext_s3 && st_r.armed;
        end
        else
        begin
            ext_rise = st_r.ext_s3 && !st_r.ext_s4 && st_r.armed;
        end
        if (st_r.ctrl[`TMC_BIT_CS])
        begin
            src_edge = ext_rise;
        end
        else
        begin
            src_edge = (st_r.phase == `TMC_INSTR_LAST);
        end
        case (st_r.ctrl[`TMC_BIT_PS_HI:`TMC_BIT_PS_LO])
            2'b00: ps_limit = 3'h0;
            2'b01: ps_limit = 3'h1;
            2'b10: ps_limit = 3'h3;
            2'b11: ps_limit = 3'h7;
            default: ps_limit = 3'h0;
        endcase
        ps_done = (st_r.ps_cnt == ps_limit);
        tick = st_r.ctrl[`TMC_BIT_RUN] && src_edge && ps_done;
    end

    // ==========================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;

        // Source mux ahead of the synchroniser; the first stage feeds only the second
        st_nxt.ext_s1 = st_r.first_ctrl[`TMC_BIT_OSC_EN] ? osc_clock_i : ext_clock_pin_i;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        st_nxt.ext_s4 = st_r.ext_s3;
        st_nxt.pin_s1 = port_pin_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.phase = st_r.phase + 2'h1;

        // A falling level must be seen before the first counted rise
        st_nxt.armed = st_r.ctrl[`TMC_BIT_RUN] && st_r.ctrl[`TMC_BIT_CS]
            && (st_r.armed || !st_r.ext_s2);

        if (st_r.ctrl[`TMC_BIT_RUN] && src_edge)
        begin
            st_nxt.ps_cnt = ps_done ? 3'h0 : st_r.ps_cnt + 3'h1;
        end

        if (tick)
        begin
            st_nxt.count = st_r.count + 16'h0001;
            if (st_r.count == `TMC_COUNT_MAX)
            begin
                st_nxt.flags[`TMC_BIT_OVF] = 1'b1;
            end
        end

        // Trigger clear is dropped when software writes the count this cycle
        if (trig && !wr_lo && !wr_hi)
        begin
            st_nxt.count = 16'h0000;
        end

        if (wr_lo)
        begin
            if (st_r.ctrl[`TMC_BIT_WIDE])
            begin
                st_nxt.count = {st_r.hbuf, wdata_i};
            end
            else
            begin
                st_nxt.count[7:0] = wdata_i;
            end
            st_nxt.ps_cnt = 3'h0;
        end
        if (wr_hi)
        begin
            if (st_r.ctrl[`TMC_BIT_WIDE])
            begin
                st_nxt.hbuf = wdata_i;
            end
            else
            begin
                st_nxt.count[15:8] = wdata_i;
            end
        end
        if (rd_lo && st_r.ctrl[`TMC_BIT_WIDE])
        begin
            st_nxt.hbuf = st_r.count[15:8];
        end

        if (wr_ctrl)
        begin
            st_nxt.ctrl = wdata_i;
            st_nxt.ps_cnt = 3'h0;
        end
        if (wr_i && (addr_i == `TMC_OFF_FIRST_CTRL))
        begin
            st_nxt.first_ctrl = wdata_i & 8'h08;
        end
        if (wr_i && (addr_i == `TMC_OFF_ENABLES))
        begin
            st_nxt.enables = wdata_i & `TMC_MASK_OVF;
        end
        if (wr_i && (addr_i == `TMC_OFF_PRIO))
        begin
            st_nxt.prio = wdata_i & `TMC_MASK_PRIO;
        end

        // Read clears the flags, but a wrap in the same cycle survives
        if (rd_flags)
        begin
            st_nxt.flags[`TMC_BIT_OVF] = tick && (st_r.count == `TMC_COUNT_MAX);
        end

        // Read data, valid in the cycle after the strobe only
        st_nxt.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `TMC_OFF_CTRL: st_nxt.rdata = st_r.ctrl;
                `TMC_OFF_COUNT_LO: st_nxt.rdata = st_r.count[7:0];
                `TMC_OFF_COUNT_HI: st_nxt.rdata = st_r.ctrl[`TMC_BIT_WIDE] ? st_r.hbuf : st_r.count[15:8];
                `TMC_OFF_FLAGS: st_nxt.rdata = st_r.flags;
                `TMC_OFF_ENABLES: st_nxt.rdata = st_r.enables;
                `TMC_OFF_PRIO: st_nxt.rdata = st_r.prio;
                `TMC_OFF_FIRST_CTRL: st_nxt.rdata = st_r.first_ctrl;
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // Outputs registered from the next state so they track without lag
        st_nxt.irq = |(st_nxt.flags & st_nxt.enables);
        st_nxt.irq_high = st_nxt.prio[`TMC_BIT_OVF];
        st_nxt.unit1_this = st_nxt.ctrl[`TMC_BIT_SEL_HI];
        st_nxt.unit2_this = st_nxt.ctrl[`TMC_BIT_SEL_HI] || st_nxt.ctrl[`TMC_BIT_SEL_LO];
        if (st_nxt.first_ctrl[`TMC_BIT_OSC_EN])
        begin
            st_nxt.port_dir = 2'b11;
            st_nxt.port_read = 2'b00;
        end
        else
        begin
            st_nxt.port_dir = port_direction_i;
            st_nxt.port_read = st_r.pin_s2;
        end
        if (!st_nxt.ctrl[`TMC_BIT_CS])
        begin
            st_nxt.mode = TMC_MODE_TIMER;
        end
        else if (st_nxt.ctrl[`TMC_BIT_UNSYNC])
        begin
            st_nxt.mode = TMC_MODE_ASYNC;
        end
        else
        begin
            st_nxt.mode = TMC_MODE_SYNC;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
            st_r.ctrl <= `TMC_RST_CTRL;
            st_r.first_ctrl <= `TMC_RST_FIRST_CTRL;
            st_r.flags <= `TMC_RST_FLAGS;
            st_r.enables <= `TMC_RST_ENABLES;
            st_r.prio <= `TMC_RST_PRIO;
            st_r.irq_high <= 1'b1;
            st_r.mode <= TMC_MODE_TIMER;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_comb
    begin
        rdata_o = st_r.rdata;
        port_direction_o = st_r.port_dir;
        port_read_o = st_r.port_read;
        count_o = st_r.count;
        unit1_this_o = st_r.unit1_this;
        unit2_this_o = st_r.unit2_this;
        irq_o = st_r.irq;
        irq_high_prio_o = st_r.irq_high;
        mode_o = st_r.mode;
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_wrap;
        tick && (st_r.count == `TMC_COUNT_MAX) && !trig && !wr_lo && !wr_hi;
    endsequence

    sequence s_wide_read;
        rd_lo && st_r.ctrl[`TMC_BIT_WIDE] && !wr_i;
    endsequence

    AST_WRAP: assert property (s_wrap |=> count_o == 16'h0000)
        else $error("Count did not wrap to zero");
    AST_OVF_FLAG: assert property (s_wrap |=> st_r.flags[`TMC_BIT_OVF] ##0 (irq_o == st_r.enables[`TMC_BIT_OVF]))
        else $error("Wrap did not latch overflow flag or irq wrong");
    // Bus master leaves one idle cycle between strobes, so the high read lands two cycles on
    AST_WIDE_RD: assert property (s_wide_read ##1 !wr_i ##1 (rd_i && addr_i == `TMC_OFF_COUNT_HI && !wr_i)
        |=> rdata_o == $past(st_r.hbuf))
        else $error("Wide high read did not return buffer");
    AST_WIDE_WR: assert property (wr_lo && st_r.ctrl[`TMC_BIT_WIDE] |=> count_o == {$past(st_r.hbuf), $past(wdata_i)})
        else $error("Wide low write did not load both bytes");
    AST_HI_NO_PS: assert property (wr_hi && st_r.ctrl[`TMC_BIT_WIDE] && !src_edge |=> st_r.ps_cnt == $past(st_r.ps_cnt))
        else $error("High buffer write disturbed prescaler");
    AST_PS_CLR: assert property ((wr_lo || wr_ctrl) |=> st_r.ps_cnt == 3'h0)
        else $error("Prescaler not cleared by write");
    AST_TRIG: assert property (trig && !wr_lo && !wr_hi && !rd_flags && !st_r.flags[`TMC_BIT_OVF]
        |=> count_o == 16'h0000 && !st_r.flags[`TMC_BIT_OVF])
        else $error("Trigger clear wrong");
    AST_WRITE_WINS: assert property (trig && wr_lo && !st_r.ctrl[`TMC_BIT_WIDE] |=> count_o[7:0] == $past(wdata_i))
        else $error("Trigger beat software write");
    AST_STOP: assert property (!st_r.ctrl[`TMC_BIT_RUN] && !wr_i && !trig |=> $stable(count_o))
        else $error("Count moved while stopped");
    AST_INT_RATE: assert property (tick && !st_r.ctrl[`TMC_BIT_CS] && !wr_i |=> !tick [*3])
        else $error("Internal source faster than instruction rate");
    AST_SEL: assert property (wr_ctrl |=> unit1_this_o == $past(wdata_i[`TMC_BIT_SEL_HI])
        && unit2_this_o == ($past(wdata_i[`TMC_BIT_SEL_HI]) || $past(wdata_i[`TMC_BIT_SEL_LO])))
        else $error("Unit timer select wrong");
    AST_OSC_PINS: assert property (st_r.first_ctrl[`TMC_BIT_OSC_EN] |-> port_read_o == 2'b00 && port_direction_o == 2'b11)
        else $error("Oscillator pins not forced to input");

endmodule

// File: tb/test_sixteen_bit_timer_counter.sv
// Self-checking bench for the sixteen-bit timer/counter
module test_sixteen_bit_timer_counter;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals and parts
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic fire_i = 1'b0;
    logic run_i = 1'b0;
    logic [3:0] cu_sel = 4'hb;
    logic [1:0] port_direction_i = 2'b00;
    logic [1:0] port_pin_i = 2'b00;
    logic [7:0] rdata_o;
    logic osc_clock;
    logic trigger;
    logic [3:0] cu_mode;
    logic [1:0] port_direction_o;
    logic [1:0] port_read_o;
    logic [15:0] count_o;
    logic unit1_this_o;
    logic unit2_this_o;
    logic irq_o;
    logic irq_high_prio_o;
    logic [1:0] mode_o;
    int bad_count = 0;
    int compares = 0;
    int seed = 32'hbcb1;
    logic [31:0] rnd;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic [11:0] tab [7] = '{12'h000, 12'h084, 12'h40c, 12'h48c, 12'h031, 12'h072, 12'h050};

    initial forever #4 clock_i = ~clock_i;

    tmc_far_model far (.clock_i(clock_i), .run_i(run_i), .fire_i(fire_i), .mode_i(cu_sel),
        .osc_clock_o(osc_clock), .trigger_o(trigger), .compare_unit_mode_o(cu_mode));

    tmc_timer dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ext_clock_pin_i(1'b0), .osc_clock_i(osc_clock),
        .trigger_i(trigger), .compare_unit_mode_i(cu_mode), .port_direction_i(port_direction_i),
        .port_pin_i(port_pin_i), .port_direction_o(port_direction_o), .port_read_o(port_read_o),
        .count_o(count_o), .unit1_this_o(unit1_this_o), .unit2_this_o(unit2_this_o), .irq_o(irq_o),
        .irq_high_prio_o(irq_high_prio_o), .mode_o(mode_o));

    // ====
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Mismatches %0d of %0d comparisons", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // Expected read data queued; monitor compares it the cycle after
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask

    always @(posedge clock_i)
    begin
        rd_d <= rd_i;
        if (rd_d)
            check(16'(rdata_o), 16'(exp_q.pop_front()));
    end

    task automatic wrap(input logic [7:0] en);
        int n;
        wr(8'h04, en);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'hfe);
        wr(8'h02, 8'hff);
        wr(8'h00, 8'h01);
        n = 0;
        while (count_o !== 16'h0000 && n < 40)
        begin
            settle(1);
            n++;
        end
        check(16'(n < 40), 16'h0001);
        check(16'(irq_o), 16'(en[1]));
        rd(8'h04, en);
        rd(8'h03, 8'h02);
        rd(8'h03, 8'h00);
        wr(8'h00, 8'h00);
        settle(2);
        check(16'(irq_o), 16'h0000);
    endtask

    // Interval between two increments, in system clocks
    task automatic pace(input logic [1:0] ps);
        logic [15:0] c;
        int n;
        wr(8'h00, {2'b00, ps, 4'h1});
        settle(1);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            c = count_o;
            while (count_o === c && n < 99)
            begin
                settle(1);
                n++;
            end
        end
        check(16'(n), 16'(4 << ps));
    endtask

    // Trigger one cycle after fire; optional low-byte write at the same edge
    task automatic trig(input logic [3:0] m, input logic ww);
        @(posedge clock_i);
        cu_sel <= m;
        fire_i <= 1'b1;
        @(posedge clock_i);
        fire_i <= 1'b0;
        addr_i <= 8'h01;
        wdata_i <= 8'h77;
        wr_i <= ww;
        @(posedge clock_i);
        wr_i <= 1'b0;
        settle(2);
    endtask

    task automatic burst(input int k);
        @(posedge clock_i);
        run_i <= 1'b1;
        repeat (16 * k) @(posedge clock_i);
        run_i <= 1'b0;
        settle(10);
    endtask

    initial
    begin
        rnd = $random(seed);
        port_pin_i = rnd[1:0];
        port_direction_i = rnd[3:2];
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h05, 8'h1f);
        rd(8'h06, 8'h00);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        check(16'(irq_high_prio_o), 16'h0001);
        foreach (tab[i])
        begin
            wr(8'h00, tab[i][11:4]);
            settle(2);
            check(16'({unit1_this_o, unit2_this_o, mode_o}), 16'(tab[i][3:0]));
            rd(8'h00, tab[i][11:4]);
        end
        wr(8'h00, 8'h00);
        repeat (4)
        begin
            rnd = $random(seed);
            wr(8'h01, rnd[7:0]);
            wr(8'h02, rnd[15:8]);
            settle(1);
            check(count_o, rnd[15:0]);
            rd(8'h02, rnd[15:8]);
        end
        // Wide mode: high byte goes through the buffer
        wr(8'h00, 8'h80);
        wr(8'h02, 8'h12);
        settle(1);
        check(count_o, rnd[15:0]);
        wr(8'h01, 8'h34);
        settle(1);
        check(count_o, 16'h1234);
        rd(8'h01, 8'h34);
        rd(8'h02, 8'h12);
        wrap(8'h00);
        wrap(8'h02);
        for (int p = 0; p < 4; p++)
            pace(2'(p));
        wr(8'h00, 8'h00);
        settle(1);
        rnd[15:0] = count_o;
        settle(40);
        check(count_o, rnd[15:0]);
        wr(8'h01, 8'h55);
        wr(8'h02, 8'h00);
        trig(4'hb, 1'b0);
        check(count_o, 16'h0000);
        rd(8'h03, 8'h00);
        wr(8'h01, 8'h55);
        trig(4'ha, 1'b0);
        check(count_o, 16'h0055);
        trig(4'hb, 1'b1);
        check(count_o, 16'h0077);
        // Shared oscillator as external source
        wr(8'h06, 8'h08);
        settle(4);
        check(16'(port_direction_o), 16'h0003);
        check(16'(port_read_o), 16'h0000);
        rd(8'h06, 8'h08);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h03);
        burst(5);
        check(count_o, 16'h0005);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h07);
        burst(3);
        check(count_o, 16'h0003);
        wr(8'h06, 8'h00);
        settle(4);
        check(16'(port_direction_o), 16'(port_direction_i));
        check(16'(port_read_o), 16'(port_pin_i));
        tally_and_finish();
    end

    initial
    begin
        repeat (30000) @(posedge clock_i);
        bad_count++;
        tally_and_finish();
    end
endmodule

// File: tb/tmc_far_model.sv
// Far-side model: compare unit trigger and shared oscillator clock
module tmc_far_model
(
    input wire logic clock_i,
    input wire logic run_i,
    input wire logic fire_i,
    input wire logic [3:0] mode_i,
    output logic osc_clock_o,
    output logic trigger_o,
    output logic [3:0] compare_unit_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Oscillator and trigger
    logic [2:0] div_r = 3'h0;
    initial osc_clock_o = 1'b0;
    initial trigger_o = 1'b0;
    // Clock stands low between bursts, so each burst starts after a low level
    always @(posedge clock_i)
    begin
        div_r <= run_i ? div_r + 3'h1 : 3'h0;
        if (!run_i)
            osc_clock_o <= 1'b0;
        else if (div_r == 3'h7)
            osc_clock_o <= ~osc_clock_o;
        trigger_o <= fire_i;
    end
    assign compare_unit_mode_o = mode_i;
endmodule
